// ==== pkg/swl_pkg.sv ====
// package for the single wire link master controller
package swl_pkg;
  localparam int CLK_MHZ = 10;
  // times in microseconds
  localparam int RESET_LOW_TIME_US = 480;
  localparam int RESET_HIGH_TIME_US = 480;
  localparam int PRESENCE_SAMPLE_US = 70;
  localparam int SLOT_TIME_US = 70;
  localparam int LOW1_TIME_US = 6;
  localparam int LOW0_TIME_US = 60;
  localparam int READ_LOW_US = 2;
  localparam int READ_SAMPLE_US = 13;
  localparam int REC_TIME_US = 2;
  localparam int PROG_TIME_US = 480;
  localparam int DELAY_PROG_US = 5;
  localparam int RESET_LOW_CYC = RESET_LOW_TIME_US * CLK_MHZ;
  localparam int RESET_HIGH_CYC = RESET_HIGH_TIME_US * CLK_MHZ;
  localparam int PRES_SAMPLE_CYC = PRESENCE_SAMPLE_US * CLK_MHZ;
  localparam int SLOT_CYC = SLOT_TIME_US * CLK_MHZ;
  localparam int LOW1_CYC = LOW1_TIME_US * CLK_MHZ;
  localparam int LOW0_CYC = LOW0_TIME_US * CLK_MHZ;
  localparam int READ_LOW_CYC = READ_LOW_US * CLK_MHZ;
  localparam int READ_SAMPLE_CYC = READ_SAMPLE_US * CLK_MHZ;
  localparam int REC_CYC = REC_TIME_US * CLK_MHZ;
  localparam int PROG_CYC = PROG_TIME_US * CLK_MHZ;
  localparam int DELAY_PROG_CYC = DELAY_PROG_US * CLK_MHZ;
  localparam int TMR_W = 13;
  // rom commands
  localparam logic [7:0] CMD_READ_ROM = 8'h33;
  localparam logic [7:0] CMD_MATCH_ROM = 8'h55;
  localparam logic [7:0] CMD_SKIP_ROM = 8'hCC;
  localparam logic [7:0] CMD_SEARCH_ROM = 8'hF0;
  // crc x^8+x^5+x^4+1, reflected
  localparam logic [7:0] CRC_POLY_REFL = 8'h8C;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W = 8;
  typedef enum logic [2:0] {
    SWL_OP_RESET, SWL_OP_WRITE, SWL_OP_READ, SWL_OP_SEARCH, SWL_OP_PROG
  } swl_op_e;
  typedef struct packed {
    swl_op_e op;
    logic [7:0] data;
  } swl_req_s;
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] crc;
    logic presence;
  } swl_rsp_s;
endpackage

// ==== verilog/swl_fifo.sv ====
// small valid/ready fifo for the link's read bytes, presence answers and search triplets
`timescale 1ns/1ps
`default_nettype none
module swl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb begin
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end
endmodule // swl_fifo
`default_nettype wire

// ==== verilog/swl_master.sv ====
// single wire link bus master: reset, slots, search triplet, program pulse
// Functional notes
// RL1: every transaction opens with master reset pulse then slave presence pulse; the master does not enforce it: idle takes any op, prog needs crc_ok
// RL2: line idles high; never leave it low over 120 us between slots
// RL3: master drives reset low at least 480 us then releases and listens
// RL4: slave waits 15-60 us after release then pulls low 60-240 us
// RL5: after presence the master sends an 8-bit rom command
// RL6: command 33h reads family code, 48-bit serial and crc
// RL7: command 55h followed by 64 bits selects one exact slave
// RL8: command CCh skips identifier and goes to memory command
// RL9: search: read bit, read complement, then write chosen bit
// RL10: slaves pull down open-drain so the line is a wired-AND
// RL11: master opens each slot by pulling the line low
// RL12: slave samples a write slot at a fixed delay after the fall
// RL13: slave holds line low for a read zero, untouched for a one
// RL14: program pulse of 480 us only after crc confirmed, then idle
// RL15: program pulse copies scratchpad into the selected memory byte
// RL16: identifier crc is top byte over first 56 bits, x^8+x^5+x^4+1
// RL17: write commands return crc over command, address and data
// RL18: read commands return crc over command and address
// RL19: read-data-with-crc gives a crc per page and for status bytes
// RL20: slave never blocks on crc; master checks and decides; here the master only outputs crc and the decision comes in on crc_ok
// RL21: master keeps standard speed data rate at or below 16.3 kbit/s
// RL22: no new sequence before 480 us reset high interval elapses
// RL23: read bit valid within 1 us of fall and held 14 us
// RL24: all microsecond intervals are counted on the fast system clock
`timescale 1ns/1ps
`default_nettype none
module swl_master (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire swl_pkg::swl_req_s req,
  input wire logic crc_clear,
  input wire logic crc_ok,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [7:0] rsp_data,
  output logic [7:0] crc,
  output logic presence,
  output logic search_bit,
  output logic search_cmp,
  output logic busy,
  input wire logic line_i,
  output logic line_o,
  output logic line_oe,
  output logic prog_en
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_RST_LOW, ST_RST_HIGH, ST_SLOT_LOW, ST_SLOT_REST,
    ST_PUSH, ST_PROG_DLY, ST_PROG, ST_PROG_REC
  } swl_st_e;
  swl_st_e st_q, st_d;
  logic [swl_pkg::TMR_W-1:0] tmr_q, tmr_d;
  logic [7:0] sh_q, sh_d, crc_q, crc_d;
  logic [2:0] bit_q, bit_d;
  logic [1:0] step_q, step_d;
  swl_pkg::swl_op_e op_q, op_d;
  logic pres_q, pres_d, sb_q, sb_d, sc_q, sc_d, smp_q, smp_d, dir_q, dir_d;
  logic sync1_q, sync2_q;
  logic push_valid, push_ready;
  logic is_read_slot, tx_bit;
  // line level passes two flops before use
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= line_i;
      sync2_q <= sync1_q;
    end
  end
  // search: steps 0,1 are read slots, step 2 writes the chosen bit
  always_comb begin
    is_read_slot = (op_q == swl_pkg::SWL_OP_READ) ||
                   ((op_q == swl_pkg::SWL_OP_SEARCH) && (step_q != 2'd2)); // RL9
    tx_bit = (op_q == swl_pkg::SWL_OP_SEARCH) ? dir_q : sh_q[0];
  end
  always_comb begin
    st_d = st_q;
    tmr_d = (tmr_q != '0) ? tmr_q - 1'b1 : tmr_q; // RL24
    sh_d = sh_q;
    crc_d = crc_q;
    bit_d = bit_q;
    step_d = step_q;
    op_d = op_q;
    pres_d = pres_q;
    sb_d = sb_q;
    sc_d = sc_q;
    smp_d = smp_q;
    dir_d = dir_q;
    if (crc_clear) begin
      crc_d = '0;
    end
    case (st_q)
      ST_IDLE: begin
        if (req_valid) begin
          op_d = req.op;
          sh_d = req.data;
          bit_d = '0;
          step_d = '0;
          dir_d = req.data[0];
          case (req.op)
            swl_pkg::SWL_OP_RESET: begin
              st_d = ST_RST_LOW; // RL1
              tmr_d = swl_pkg::TMR_W'(swl_pkg::RESET_LOW_CYC - 1); // RL3
            end
            swl_pkg::SWL_OP_PROG: begin
              if (crc_ok) begin
                st_d = ST_PROG_DLY; // RL14
                tmr_d = swl_pkg::TMR_W'(swl_pkg::DELAY_PROG_CYC - 1);
              end
            end
            default: begin
              st_d = ST_SLOT_LOW; // RL11
              tmr_d = swl_pkg::TMR_W'(swl_pkg::SLOT_CYC - 1);
            end
          endcase
        end
      end
      ST_RST_LOW: begin
        if (tmr_q == '0) begin
          st_d = ST_RST_HIGH;
          pres_d = 1'b0;
          tmr_d = swl_pkg::TMR_W'(swl_pkg::RESET_HIGH_CYC - 1); // RL22
        end
      end
      ST_RST_HIGH: begin
        // sample after slave wait 15-60 us, inside its low window
        if (tmr_q == swl_pkg::TMR_W'(swl_pkg::RESET_HIGH_CYC -
            swl_pkg::PRES_SAMPLE_CYC) && !sync2_q) begin
          pres_d = 1'b1; // RL4
        end
        if (tmr_q == '0) begin
          st_d = ST_PUSH;
          sh_d = {7'h00, pres_q};
        end
      end
      ST_SLOT_LOW: begin
        if (tmr_q == swl_pkg::TMR_W'(swl_pkg::SLOT_CYC -
            swl_pkg::READ_SAMPLE_CYC)) begin
          smp_d = sync2_q; // RL23
        end
        if (tmr_q == '0) begin
          st_d = ST_SLOT_REST;
          tmr_d = swl_pkg::TMR_W'(swl_pkg::REC_CYC - 1);
        end
      end
      ST_SLOT_REST: begin
        if (tmr_q == '0) begin
          if (op_q == swl_pkg::SWL_OP_SEARCH) begin
            if (step_q == 2'd0) begin
              sb_d = smp_q;
              step_d = 2'd1;
              st_d = ST_SLOT_LOW;
            end else if (step_q == 2'd1) begin
              sc_d = smp_q;
              step_d = 2'd2;
              // both 1: no slave; bits differ: forced direction
              if (sb_q != smp_q) begin
                dir_d = sb_q;
              end
              st_d = ST_SLOT_LOW;
            end else begin
              crc_d = {1'b0, crc_q[7:1]} ^
                      ((crc_q[0] ^ dir_q) ? swl_pkg::CRC_POLY_REFL : 8'h00);
              sh_d = {5'h00, sb_q, sc_q, dir_q};
              st_d = ST_PUSH;
            end
            tmr_d = swl_pkg::TMR_W'(swl_pkg::SLOT_CYC - 1);
          end else begin
            // lsb first; crc follows every bit seen on the line
            sh_d = {is_read_slot ? smp_q : sh_q[0], sh_q[7:1]};
            crc_d = {1'b0, crc_q[7:1]} ^
                    ((crc_q[0] ^ (is_read_slot ? smp_q : sh_q[0])) ?
                     swl_pkg::CRC_POLY_REFL : 8'h00); // RL16
            bit_d = bit_q + 1'b1;
            tmr_d = swl_pkg::TMR_W'(swl_pkg::SLOT_CYC - 1);
            if (bit_q == 3'd7) begin // RL5
              st_d = is_read_slot ? ST_PUSH : ST_IDLE;
            end else begin
              st_d = ST_SLOT_LOW;
            end
          end
        end
      end
      ST_PUSH: begin
        if (push_ready) begin
          st_d = ST_IDLE;
        end
      end
      ST_PROG_DLY: begin
        if (tmr_q == '0) begin
          st_d = ST_PROG;
          tmr_d = swl_pkg::TMR_W'(swl_pkg::PROG_CYC - 1);
        end
      end
      ST_PROG: begin
        if (tmr_q == '0) begin
          st_d = ST_PROG_REC; // RL15
          tmr_d = swl_pkg::TMR_W'(swl_pkg::DELAY_PROG_CYC - 1);
        end
      end
      ST_PROG_REC: begin
        if (tmr_q == '0) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      tmr_q <= '0;
      sh_q <= '0;
      crc_q <= '0;
      bit_q <= '0;
      step_q <= '0;
      op_q <= swl_pkg::SWL_OP_RESET;
      pres_q <= 1'b0;
      sb_q <= 1'b0;
      sc_q <= 1'b0;
      smp_q <= 1'b1;
      dir_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      sh_q <= sh_d;
      crc_q <= crc_d;
      bit_q <= bit_d;
      step_q <= step_d;
      op_q <= op_d;
      pres_q <= pres_d;
      sb_q <= sb_d;
      sc_q <= sc_d;
      smp_q <= smp_d;
      dir_q <= dir_d;
    end
  end
  // pin drive: low only, the pull-up makes the high level
  logic drv_q, drv_d, prog_q, prog_d;
  always_comb begin
    drv_d = 1'b0;
    prog_d = 1'b0;
    case (st_d)
      ST_RST_LOW: drv_d = 1'b1; // RL3
      ST_SLOT_LOW: begin
        if (is_read_slot) begin
          drv_d = tmr_d > swl_pkg::TMR_W'(swl_pkg::SLOT_CYC -
                  swl_pkg::READ_LOW_CYC - 1); // RL11
        end else if (tx_bit) begin
          drv_d = tmr_d > swl_pkg::TMR_W'(swl_pkg::SLOT_CYC -
                  swl_pkg::LOW1_CYC - 1);
        end else begin
          drv_d = tmr_d > swl_pkg::TMR_W'(swl_pkg::SLOT_CYC -
                  swl_pkg::LOW0_CYC - 1); // RL21
        end
      end
      ST_PROG: prog_d = 1'b1; // RL14
      default: drv_d = 1'b0; // RL2
    endcase
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      drv_q <= 1'b0;
      prog_q <= 1'b0;
    end else begin
      drv_q <= drv_d;
      prog_q <= prog_d;
    end
  end
  assign line_o = 1'b0; // RL10
  assign line_oe = drv_q;
  assign prog_en = prog_q;
  assign req_ready = (st_q == ST_IDLE) &&
                     ((req.op != swl_pkg::SWL_OP_PROG) || crc_ok);
  assign push_valid = (st_q == ST_PUSH);
  assign busy = (st_q != ST_IDLE);
  assign crc = crc_q; // RL20
  assign presence = pres_q;
  assign search_bit = sb_q;
  assign search_cmp = sc_q;
  swl_fifo #(
    .WIDTH(swl_pkg::FIFO_W),
    .DEPTH(swl_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .rst(rst),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(sh_q),
    .out_valid(rsp_valid),
    .out_ready(rsp_ready),
    .out_data(rsp_data)
  );
endmodule // swl_master
`default_nettype wire

// ==== test/swl_slave_model.sv ====
// behavioural model of the one-line memory device on the far side
`timescale 1ns/1ps
`default_nettype none
module swl_slave_model (
  input wire logic line,
  input wire logic present,
  input wire logic search_mode,
  input wire logic [7:0] tx_byte,
  output logic pull_low,
  output logic [7:0] rx_byte
);
  int idx = 0;
  int step = 0;
  logic dropped = 1'b0;
  logic bit_out;
  realtime t0;
  initial pull_low = 1'b0;
  initial rx_byte = 8'h00;
  // every fall starts the internal delay; own falls are missed while busy
  always @(negedge line) begin
    if (present) begin
      t0 = $realtime;
      bit_out = dropped | (search_mode && step == 2) |
        (tx_byte[idx] ^ (search_mode && step == 1));
      pull_low = !bit_out;
      #15000 pull_low = 1'b0;
      #15000;
      rx_byte = {line, rx_byte[7:1]};
      if (search_mode && step == 2 && line != tx_byte[idx])
        dropped = 1'b1;
      if (!line)
        @(posedge line);
      if ($realtime - t0 >= 480000.0) begin
        idx = 0;
        step = 0;
        dropped = 1'b0;
        #30000 pull_low = 1'b1;
        #120000 pull_low = 1'b0;
      end else if (search_mode) begin
        step = (step + 1) % 3;
        if (step == 0)
          idx = (idx + 1) % 8;
      end else begin
        idx = (idx + 1) % 8;
      end
    end
  end
endmodule // swl_slave_model
`default_nettype wire

// ==== test/swl_master_assertions.sv ====
// assertion checker watching the link master's ports
`timescale 1ns/1ps
`default_nettype none
module swl_master_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire swl_pkg::swl_req_s req,
  input wire logic crc_ok,
  input wire logic busy,
  input wire logic line_o,
  input wire logic line_oe,
  input wire logic prog_en
);
  localparam int RSTL = swl_pkg::RESET_LOW_CYC;
  localparam int RMAX = 960 * swl_pkg::CLK_MHZ;
  localparam int PMAX = 5000 * swl_pkg::CLK_MHZ;
  logic [15:0] low_q, low_d, pp_q, pp_d;
  // lengths of the current pull-down and program pulse
  always_comb begin
    low_d = line_oe ? low_q + 16'h0001 : 16'h0000;
    pp_d = prog_en ? pp_q + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      low_q <= 16'h0000;
      pp_q <= 16'h0000;
    end else begin
      low_q <= low_d;
      pp_q <= pp_d;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_take;
    req_valid && req_ready;
  endsequence
  sequence s_low_end;
    $fell(line_oe);
  endsequence
  prog_gate_a: assert property (
    req_valid && !crc_ok && req.op == swl_pkg::SWL_OP_PROG |-> !req_ready
  ) else $error("program taken without crc ok");
  prog_width_a: assert property (
    $fell(prog_en) |-> int'(pp_q) >= swl_pkg::PROG_CYC && int'(pp_q) <= PMAX
  ) else $error("program pulse width wrong");
  prog_quiet_a: assert property (prog_en |-> !line_oe)
    else $error("line pulled low during program pulse");
  reset_low_a: assert property (
    s_low_end ##0 int'(low_q) > 1200 |->
      int'(low_q) >= RSTL && int'(low_q) <= RMAX
  ) else $error("reset pulse length wrong");
  slot_low_a: assert property (
    s_low_end |-> int'(low_q) <= 1200 || int'(low_q) >= RSTL
  ) else $error("line held low too long");
  recovery_a: assert property (s_low_end |-> !line_oe [*8])
    else $error("slot reopened without recovery");
  take_busy_a: assert property (s_take |=> busy)
    else $error("request taken but not busy");
  slot_open_a: assert property (
    s_take ##0 req.op != swl_pkg::SWL_OP_PROG |-> ##[1:3] line_oe
  ) else $error("operation not opened by a fall");
  open_drain_a: assert property (line_oe |-> line_o == 1'b0)
    else $error("line driven high");
endmodule // swl_master_checker
bind swl_master swl_master_checker u_chk (.ref_clk, .rst, .req_valid,
  .req_ready, .req, .crc_ok, .busy, .line_o, .line_oe, .prog_en);
`default_nettype wire

// ==== test/swl_master_tb.sv ====
// testbench for the single wire link master
`timescale 1ns/1ps
`default_nettype none
module swl_master_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic crc_clear = 1'b0;
  logic crc_ok = 1'b0;
  logic rsp_ready = 1'b0;
  logic present = 1'b1;
  logic search_mode = 1'b0;
  logic [7:0] tx_byte = 8'hFF;
  swl_pkg::swl_req_s req = '0;
  logic req_ready, rsp_valid, presence, search_bit, search_cmp, busy;
  logic line_o, line_oe, prog_en, pull_low;
  logic [7:0] rsp_data, crc, rx_byte;
  wire logic line;
  int bad_count = 0;
  int n_compared = 0;
  // pull-up: the line is high unless someone pulls it down
  assign line = !(line_oe || pull_low);
  always #50 ref_clk = ~ref_clk;
  swl_master DUT (.ref_clk, .rst, .req_valid, .req_ready, .req, .crc_clear,
    .crc_ok, .rsp_valid, .rsp_ready, .rsp_data, .crc, .presence, .search_bit,
    .search_cmp, .busy, .line_i(line), .line_o, .line_oe, .prog_en);
  swl_slave_model u_dev (.line, .present, .search_mode, .tx_byte, .pull_low,
    .rx_byte);
  task automatic chk(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] d);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++)
      r = (r >> 1) ^ ((r[0] ^ d[i]) ? 8'h8C : 8'h00);
    return r;
  endfunction
  task automatic issue(input swl_pkg::swl_op_e op, input logic [7:0] d);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req <= {op, d};
    for (int i = 0; i < 30000; i++) begin
      @(negedge ref_clk);
      if (req_ready === 1'b1)
        break;
    end
    @(posedge ref_clk);
    req_valid <= 1'b0;
  endtask
  task automatic pop(input string what, input logic [7:0] exp);
    @(negedge ref_clk);
    for (int i = 0; i < 30000 && rsp_valid !== 1'b1; i++)
      @(negedge ref_clk);
    chk({what, " valid"}, 16'h0001, {15'h0000, rsp_valid});
    chk(what, {8'h00, exp}, {8'h00, rsp_data});
    @(posedge ref_clk);
    rsp_ready <= 1'b1;
    @(posedge ref_clk);
    rsp_ready <= 1'b0;
  endtask
  task automatic op_crc(input swl_pkg::swl_op_e op, input logic [7:0] d,
    input logic [7:0] tx);
    @(posedge ref_clk);
    tx_byte <= tx;
    crc_clear <= 1'b1;
    @(posedge ref_clk);
    crc_clear <= 1'b0;
    issue(op, d);
  endtask
  task automatic t_reset(input logic p);
    @(posedge ref_clk);
    present <= p;
    issue(swl_pkg::SWL_OP_RESET, 8'h00);
    pop("reset answer", {7'h00, p});
    chk("presence", {15'h0000, p}, {15'h0000, presence});
    $display("test reset with device %0d done", p);
  endtask
  task automatic t_write(input logic [7:0] cmd);
    op_crc(swl_pkg::SWL_OP_WRITE, cmd, 8'hFF);
    @(negedge ref_clk);
    for (int i = 0; i < 30000 && busy !== 1'b0; i++)
      @(negedge ref_clk);
    chk("write finished", 16'h0000, {15'h0000, busy});
    chk("written byte", {8'h00, cmd}, {8'h00, rx_byte});
    chk("write crc", {8'h00, crc8(cmd)}, {8'h00, crc});
    $display("test write %h done", cmd);
  endtask
  task automatic t_read;
    op_crc(swl_pkg::SWL_OP_READ, 8'h00, 8'h3C);
    pop("read byte", 8'h3C);
    chk("read crc", {8'h00, crc8(8'h3C)}, {8'h00, crc});
    $display("test read done");
  endtask
  task automatic t_search;
    logic b;
    t_reset(1'b1);
    @(posedge ref_clk);
    search_mode <= 1'b1;
    tx_byte <= 8'h96;
    for (int i = 0; i < 9; i++)
      issue(swl_pkg::SWL_OP_SEARCH, {7'h00, i[0]});
    repeat (3000) @(negedge ref_clk);
    chk("stalled on full buffer", 16'h0001, {15'h0000, busy});
    for (int i = 0; i < 9; i++) begin
      b = tx_byte[i % 8];
      pop("search triplet", {5'h00, b, !b, b});
    end
    chk("search bit", {15'h0000, tx_byte[0]}, {15'h0000, search_bit});
    chk("search cmp", {15'h0000, !tx_byte[0]}, {15'h0000, search_cmp});
    // no device: both reads float high, so the preferred bit is written
    @(posedge ref_clk);
    present <= 1'b0;
    issue(swl_pkg::SWL_OP_SEARCH, 8'h00);
    pop("search no device", 8'h06);
    @(posedge ref_clk);
    search_mode <= 1'b0;
    present <= 1'b1;
    $display("test search and buffer done");
  endtask
  task automatic t_prog;
    int n;
    n = 0;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req <= {swl_pkg::SWL_OP_PROG, 8'h00};
    repeat (20) @(negedge ref_clk);
    chk("program refused", 16'h0000, {15'h0000, busy | prog_en});
    @(posedge ref_clk);
    crc_ok <= 1'b1;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    for (int i = 0; i < 8000; i++) begin
      @(negedge ref_clk);
      if (prog_en === 1'b1)
        n++;
    end
    chk("program cycles", 16'(swl_pkg::PROG_CYC), n[15:0]);
    @(posedge ref_clk);
    crc_ok <= 1'b0;
    $display("test program pulse done");
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset(1'b0);
    t_reset(1'b1);
    t_write(swl_pkg::CMD_READ_ROM);
    t_write(swl_pkg::CMD_SKIP_ROM);
    t_read();
    t_search();
    t_prog();
    results();
  end
  initial begin
    repeat (95000) @(posedge ref_clk);
    bad_count++;
    results();
  end
endmodule // swl_master_tb
`default_nettype wire
